/* File: design/t8c_pkg.sv */
// Operation
// - eight-bit counter, two compare registers, comparators
// - flags visible, each gated by mask bit
// - overflow, match A, match B interrupt sources
// - tick from prescaler or external pin edge
// - select zero stops the counter
// - tick clears, increments or decrements counter
// - counter writable anytime, write beats counting
// - mode bits split over control A, B
// - 0x00 is bottom, 0xff is maximum
// - top is 0xff or compare A
// - overflow flag set per waveform mode
// - equality sets match flag on tick
// - flag cleared by service or writing one
// - wave outputs from match, mode, action
// - pwm compare double buffered, updated at top
// - software reaches buffer or working register
// - force updates output outside pwm modes, no flag, no clear
// - counter write blocks next tick's matches
// - mode zero wraps, overflow at zero
// - mode two clears on compare A match
// - action zero leaves output untouched
package t8c_pkg;
    // register byte offsets
    localparam logic [4:0] ADDR_CTRL_A = 5'h00;
    localparam logic [4:0] ADDR_CTRL_B = 5'h04;
    localparam logic [4:0] ADDR_COUNT  = 5'h08;
    localparam logic [4:0] ADDR_CMP_A  = 5'h0c;
    localparam logic [4:0] ADDR_CMP_B  = 5'h10;
    localparam logic [4:0] ADDR_MASK   = 5'h14;
    localparam logic [4:0] ADDR_FLAGS  = 5'h18;
    // control field positions
    localparam int CA_WGM_LO  = 0;
    localparam int CA_COMB_LO = 4;
    localparam int CA_COMA_LO = 6;
    localparam int CB_WGM2    = 3;
    localparam int CB_FORCE_B = 6;
    localparam int CB_FORCE_A = 7;
    // flag and mask bit positions
    localparam int FLAG_OVF = 0;
    localparam int FLAG_A   = 1;
    localparam int FLAG_B   = 2;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_CB   = 4'h0;
    localparam logic [2:0] RST_BITS = 3'h0;
    // counter extremes
    localparam logic [7:0] BOTTOM = 8'h00;
    localparam logic [7:0] MAX    = 8'hff;
    // waveform modes
    localparam logic [2:0] MODE_NORMAL    = 3'h0;
    localparam logic [2:0] MODE_PHASE     = 3'h1;
    localparam logic [2:0] MODE_CTC       = 3'h2;
    localparam logic [2:0] MODE_FAST      = 3'h3;
    localparam logic [2:0] MODE_PHASE_OCR = 3'h5;
    localparam logic [2:0] MODE_FAST_OCR  = 3'h7;
    // compare output actions
    localparam logic [1:0] COM_OFF    = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    // clock select codes
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_D64  = 3'h3;
    localparam logic [2:0] CS_D256 = 3'h4;
    localparam logic [2:0] CS_D1K  = 3'h5;
    localparam logic [2:0] CS_FALL = 3'h6;
    localparam logic [2:0] CS_RISE = 3'h7;
    // prescaler terminal masks (divide minus one)
    localparam logic [9:0] PRE_M8   = 10'h007;
    localparam logic [9:0] PRE_M64  = 10'h03f;
    localparam logic [9:0] PRE_M256 = 10'h0ff;
    localparam logic [9:0] PRE_M1K  = 10'h3ff;
    localparam logic [9:0] PRE_ONE  = 10'h001;
    // bus handshake states, one-hot
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } t8c_bus_e;
    // avalon request bundle
    typedef struct packed {
        logic        read;
        logic        write;
        logic [4:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } t8c_bus_req_s;
    // whole core state
    typedef struct packed {
        t8c_bus_e    bus;
        logic [31:0] rdata;
        logic [7:0]  ctrl_a;
        logic [3:0]  ctrl_b;
        logic [7:0]  count;
        logic [7:0]  ocr_a;
        logic [7:0]  ocr_b;
        logic [7:0]  buf_a;
        logic [7:0]  buf_b;
        logic [2:0]  mask;
        logic [2:0]  flags;
        logic        down;
        logic        block;
        logic        wave_a;
        logic        wave_b;
    } t8c_core_s;
endpackage

/* File: design/t8c_tick_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module t8c_tick_gen
    import t8c_pkg::*;
(
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    // source selection
    input  wire logic [2:0] i_select,
    input  wire logic       i_ext,
    // timer tick, one-cycle pulse
    output logic            o_tick
);
    // prescaler, last pin level, tick
    typedef struct packed {
        logic [9:0] pre;
        logic       ext_prev;
        logic       tick;
    } t8c_tick_s;

    t8c_tick_s st_q;  // registered state
    t8c_tick_s st_d;  // next state

    // free-running prescaler so divided ticks need no restart
    always_comb begin
        st_d          = st_q;
        st_d.pre      = st_q.pre + PRE_ONE;
        st_d.ext_prev = i_ext;
        case (i_select)
            CS_STOP: st_d.tick = 1'b0;
            CS_DIV1: st_d.tick = 1'b1;
            CS_DIV8: st_d.tick = (st_q.pre & PRE_M8) == PRE_M8;
            CS_D64:  st_d.tick = (st_q.pre & PRE_M64) == PRE_M64;
            CS_D256: st_d.tick = (st_q.pre & PRE_M256) == PRE_M256;
            CS_D1K:  st_d.tick = st_q.pre == PRE_M1K;
            CS_FALL: st_d.tick = st_q.ext_prev & ~i_ext;
            CS_RISE: st_d.tick = ~st_q.ext_prev & i_ext;
            default: st_d.tick = 1'b0;
        endcase
    end

    // state register
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_tick = st_q.tick;
endmodule
`default_nettype wire

/* File: design/t8c_core.sv */
// Design decisions made here: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module t8c_core
    import t8c_pkg::*;
(
    // clock and reset
    input  wire logic         I_REF_CLK,
    input  wire logic         I_RESET,
    // avalon-mm slave
    input  wire t8c_bus_req_s I_BUS_REQ,
    output logic              O_WAITREQUEST,
    output logic [31:0]       O_READDATA,
    // external count pin
    input  wire logic         I_EXT_COUNT_INPUT,
    // interrupt service acknowledge, per source
    input  wire logic [2:0]   I_INT_ACK,
    // interrupt requests, per source
    output logic [2:0]        O_INT_REQ,
    // compare outputs
    output logic              O_WAVE_OUT_A,
    output logic              O_WAVE_OUT_B
);
    t8c_core_s  st_q;        // registered state
    t8c_core_s  st_d;        // next state
    logic       timer_tick;  // one-cycle count enable
    logic [2:0] waveform_mode;
    logic       is_pwm;      // double buffered modes
    logic [7:0] top_val;     // end of sequence
    logic       at_bottom;
    logic       at_max;
    logic       at_top;
    logic       eq_a;        // raw comparator outputs
    logic       eq_b;
    logic       match_a;     // matches after blocking
    logic       match_b;
    logic       wr_go;       // write completes this edge
    logic       cnt_wr;      // counter write this edge
    logic [2:0] flag_set;
    logic [2:0] flag_clr;
    logic [31:0] rd_val;

    // tick source and prescaler
    t8c_tick_gen u_tick (
        .i_clk    (I_REF_CLK),
        .i_reset  (I_RESET),
        .i_select (st_q.ctrl_b[2:0]),
        .i_ext    (I_EXT_COUNT_INPUT),
        .o_tick   (timer_tick)
    );

    // one output step for a compare unit
    function automatic logic wave_step(input logic [1:0] com, input logic cur,
                                       input logic [2:0] mode, input logic hit,
                                       input logic wrap, input logic down);
        logic res;
        res = cur;
        // action zero never touches the output
        if (!mode[0] && com != COM_OFF) begin
            // non-pwm: toggle, clear or set on match
            if (hit) begin
                res = (com == COM_TOGGLE) ? ~cur : com[0];
            end
        end else if (mode[0] && com[1]) begin
            if (mode[1]) begin
                // fast pwm: match sets level, wrap restores it
                if (hit) begin
                    res = com[0];
                end else if (wrap) begin
                    res = ~com[0];
                end
            end else if (hit) begin
                // phase correct: level depends on direction
                res = com[0] ^ down;
            end
        end
        return res;
    endfunction

    // mode bits from both control registers
    assign waveform_mode = {st_q.ctrl_b[CB_WGM2], st_q.ctrl_a[CA_WGM_LO +: 2]};
    assign is_pwm        = waveform_mode[0];
    // top is compare A in ctc and high modes
    assign top_val = (waveform_mode == MODE_CTC || waveform_mode[2]) ? st_q.ocr_a : MAX;
    assign at_bottom = st_q.count == BOTTOM;
    assign at_max    = st_q.count == MAX;
    assign at_top    = st_q.count == top_val;
    assign eq_a = st_q.count == st_q.ocr_a;
    assign eq_b = st_q.count == st_q.ocr_b;
    // a recent counter write masks matches
    assign match_a = eq_a & ~st_q.block;
    assign match_b = eq_b & ~st_q.block;
    // low byte lane carries all register data
    assign wr_go  = I_BUS_REQ.write && st_q.bus == BUS_ACK && I_BUS_REQ.byteenable[0];
    assign cnt_wr = wr_go && I_BUS_REQ.address == ADDR_COUNT;

    // read mux, unmapped reads return zero
    always_comb begin
        rd_val = 32'h0000_0000;
        case (I_BUS_REQ.address)
            ADDR_CTRL_A: rd_val[7:0] = st_q.ctrl_a;
            ADDR_CTRL_B: rd_val[3:0] = st_q.ctrl_b;
            ADDR_COUNT:  rd_val[7:0] = st_q.count;
            ADDR_CMP_A:  rd_val[7:0] = is_pwm ? st_q.buf_a : st_q.ocr_a;
            ADDR_CMP_B:  rd_val[7:0] = is_pwm ? st_q.buf_b : st_q.ocr_b;
            ADDR_MASK:   rd_val[2:0] = st_q.mask;
            ADDR_FLAGS:  rd_val[2:0] = st_q.flags;
            default:     rd_val = 32'h0000_0000;
        endcase
    end

    // next state of the whole block
    always_comb begin
        st_d     = st_q;
        flag_set = RST_BITS;
        flag_clr = I_INT_ACK;
        // bus handshake, one wait cycle per access
        case (st_q.bus)
            BUS_IDLE: begin
                if (I_BUS_REQ.read || I_BUS_REQ.write) begin
                    st_d.bus   = BUS_ACK;
                    st_d.rdata = rd_val;
                end
            end
            BUS_ACK: st_d.bus = BUS_IDLE;
            default: st_d.bus = BUS_IDLE;
        endcase
        // counting work happens only on ticks
        if (timer_tick) begin
            // blocking lasts exactly one tick
            st_d.block = 1'b0;
            case (waveform_mode)
                MODE_CTC, MODE_FAST, MODE_FAST_OCR: begin
                    st_d.count = at_top ? BOTTOM : st_q.count + 8'h01;
                end
                MODE_PHASE, MODE_PHASE_OCR: begin
                    if (at_top) begin
                        st_d.down = 1'b1;
                    end else if (at_bottom) begin
                        st_d.down = 1'b0;
                    end
                    st_d.count = st_d.down ? st_q.count - 8'h01 : st_q.count + 8'h01;
                end
                // plain up count wrapping at max
                default: st_d.count = st_q.count + 8'h01;
            endcase
            case (waveform_mode)
                MODE_FAST, MODE_FAST_OCR:   flag_set[FLAG_OVF] = at_top;
                MODE_PHASE, MODE_PHASE_OCR: flag_set[FLAG_OVF] = at_bottom;
                default:                    flag_set[FLAG_OVF] = at_max;
            endcase
            flag_set[FLAG_A] = match_a;
            flag_set[FLAG_B] = match_b;
            st_d.wave_a = wave_step(st_q.ctrl_a[CA_COMA_LO +: 2], st_q.wave_a,
                                    waveform_mode, match_a, at_top, st_q.down);
            st_d.wave_b = wave_step(st_q.ctrl_a[CA_COMB_LO +: 2], st_q.wave_b,
                                    waveform_mode, match_b, at_top, st_q.down);
            // working copy loads at top in pwm
            if (is_pwm && at_top) begin
                st_d.ocr_a = st_q.buf_a;
                st_d.ocr_b = st_q.buf_b;
            end
        end
        // software writes come last so they win
        if (wr_go) begin
            case (I_BUS_REQ.address)
                ADDR_CTRL_A: st_d.ctrl_a = I_BUS_REQ.writedata[7:0];
                ADDR_CTRL_B: begin
                    st_d.ctrl_b = I_BUS_REQ.writedata[3:0];
                    // forced match moves only the output
                    if (!is_pwm && I_BUS_REQ.writedata[CB_FORCE_A]) begin
                        st_d.wave_a = wave_step(st_q.ctrl_a[CA_COMA_LO +: 2], st_d.wave_a,
                                                MODE_NORMAL, 1'b1, 1'b0, 1'b0);
                    end
                    if (!is_pwm && I_BUS_REQ.writedata[CB_FORCE_B]) begin
                        st_d.wave_b = wave_step(st_q.ctrl_a[CA_COMB_LO +: 2], st_d.wave_b,
                                                MODE_NORMAL, 1'b1, 1'b0, 1'b0);
                    end
                end
                ADDR_COUNT: begin
                    st_d.count = I_BUS_REQ.writedata[7:0];
                    st_d.block = 1'b1;
                end
                ADDR_CMP_A: begin
                    st_d.buf_a = I_BUS_REQ.writedata[7:0];
                    if (!is_pwm) begin
                        st_d.ocr_a = I_BUS_REQ.writedata[7:0];
                    end
                end
                ADDR_CMP_B: begin
                    st_d.buf_b = I_BUS_REQ.writedata[7:0];
                    if (!is_pwm) begin
                        st_d.ocr_b = I_BUS_REQ.writedata[7:0];
                    end
                end
                ADDR_MASK:  st_d.mask = I_BUS_REQ.writedata[2:0];
                ADDR_FLAGS: flag_clr = flag_clr | I_BUS_REQ.writedata[2:0];
                default:    st_d.mask = st_q.mask;
            endcase
        end
        // three sticky sources, a new event beats a clear
        st_d.flags = (st_q.flags & ~flag_clr) | flag_set;
    end

    // state register
    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            st_q        <= '0;
            st_q.bus    <= BUS_IDLE;
            st_q.ctrl_a <= RST_BYTE;
            st_q.ctrl_b <= RST_CB;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs
    assign O_WAITREQUEST = (I_BUS_REQ.read || I_BUS_REQ.write) && st_q.bus != BUS_ACK;
    assign O_READDATA    = st_q.rdata;
    // each request gated by its mask bit
    assign O_INT_REQ     = st_q.flags & st_q.mask;
    assign O_WAVE_OUT_A  = st_q.wave_a;
    assign O_WAVE_OUT_B  = st_q.wave_b;

    // checks
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (I_RESET);

    sequence s_force_a;
        wr_go && I_BUS_REQ.address == ADDR_CTRL_B && I_BUS_REQ.writedata[CB_FORCE_A]
            && !is_pwm && st_q.ctrl_a[CA_COMA_LO +: 2] == COM_TOGGLE;
    endsequence
    sequence s_quiet_a;
        !timer_tick && !I_INT_ACK[FLAG_A];
    endsequence

    // counting checks
    stop_no_tick_a: assert property (
        (st_q.ctrl_b[2:0] == CS_STOP)[*2] |-> !timer_tick)
        else $error("tick while stopped");

    count_step_a: assert property (
        timer_tick && !cnt_wr && waveform_mode == MODE_NORMAL
        |=> st_q.count == 8'($past(st_q.count) + 8'h01))
        else $error("normal mode did not increment");

    write_prio_a: assert property (
        cnt_wr |=> st_q.count == $past(I_BUS_REQ.writedata[7:0]) && st_q.block)
        else $error("counter write lost");

    ovf_wrap_a: assert property (
        timer_tick && !cnt_wr && waveform_mode == MODE_NORMAL && at_max
        |=> st_q.count == BOTTOM && st_q.flags[FLAG_OVF])
        else $error("wrap without overflow");

    ctc_clear_a: assert property (
        timer_tick && !cnt_wr && waveform_mode == MODE_CTC && eq_a
        |=> st_q.count == BOTTOM)
        else $error("ctc did not clear");

    // compare and flag checks
    match_flag_a: assert property (
        timer_tick && eq_b && !st_q.block |=> st_q.flags[FLAG_B])
        else $error("match flag not set");

    block_match_a: assert property (
        timer_tick && st_q.block && !st_q.flags[FLAG_A] |=> !st_q.flags[FLAG_A])
        else $error("blocked match set flag");

    force_out_a: assert property (
        s_force_a and s_quiet_a
        |=> st_q.wave_a != $past(st_q.wave_a) && st_q.flags[FLAG_A] == $past(st_q.flags[FLAG_A])
            && st_q.count == $past(st_q.count) ##1 1'b1)
        else $error("force misbehaved");

    ack_clear_a: assert property (
        I_INT_ACK[FLAG_A] && !(timer_tick && match_a) |=> !st_q.flags[FLAG_A] ##1 1'b1)
        else $error("service did not clear flag");

    // counter holds between ticks and writes
    count_hold_a: assert property (
        !timer_tick && !cnt_wr |=> st_q.count == $past(st_q.count))
        else $error("count moved without tick");

    // clear-on-match never passes compare a
    ctc_top_a: assert property (
        timer_tick && !cnt_wr && waveform_mode == MODE_CTC && st_q.count < st_q.ocr_a
        |=> st_q.count <= $past(st_q.ocr_a))
        else $error("count passed top");

    // fast modes flag overflow at top
    ovf_top_a: assert property (
        timer_tick && waveform_mode[1:0] == MODE_FAST[1:0] && at_top
        |=> st_q.flags[FLAG_OVF])
        else $error("no overflow at top");

    // direct compare write outside pwm
    cmp_direct_a: assert property (
        wr_go && I_BUS_REQ.address == ADDR_CMP_A && !is_pwm
        |=> st_q.ocr_a == $past(I_BUS_REQ.writedata[7:0]))
        else $error("compare write missed");

    // pwm compare write stays in the buffer
    cmp_buffer_a: assert property (
        wr_go && I_BUS_REQ.address == ADDR_CMP_A && is_pwm && !timer_tick
        |=> st_q.buf_a == $past(I_BUS_REQ.writedata[7:0]) && $stable(st_q.ocr_a))
        else $error("buffer write leaked");

    // working copy loads from buffer at top
    buf_load_a: assert property (
        timer_tick && is_pwm && at_top |=> st_q.ocr_a == $past(st_q.buf_a))
        else $error("working copy not loaded");

    // toggle action flips output on a match
    toggle_out_a: assert property (
        timer_tick && !is_pwm && match_a && !wr_go
            && st_q.ctrl_a[CA_COMA_LO +: 2] == COM_TOGGLE
        |=> st_q.wave_a != $past(st_q.wave_a))
        else $error("toggle missed");

    // action zero keeps output b as it is
    idle_out_a: assert property (
        st_q.ctrl_a[CA_COMB_LO +: 2] == COM_OFF |=> $stable(st_q.wave_b))
        else $error("idle output moved");

    // software write of one clears flag b
    sw_clear_a: assert property (
        wr_go && I_BUS_REQ.address == ADDR_FLAGS && I_BUS_REQ.writedata[FLAG_B]
            && !(timer_tick && match_b)
        |=> !st_q.flags[FLAG_B])
        else $error("write one did not clear");
endmodule
`default_nettype wire

/* File: tb/t8c_core_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module t8c_core_tb_top
    import t8c_pkg::*;
;
    // bench-side copies of the design ports
    logic         clk;         // reference clock
    logic         reset;       // synchronous reset
    t8c_bus_req_s req;         // avalon request bundle
    logic         ext;         // external count pin
    logic [2:0]   ack;         // service acknowledge
    wire  logic        wait_req;    // avalon waitrequest
    wire  logic [31:0] rdata;       // avalon read data
    wire  logic [2:0]  int_req;     // interrupt lines
    wire  logic        wave_a;      // compare output a
    wire  logic        wave_b;      // compare output b
    int           n_mismatch;  // mismatches seen
    int           check_count; // comparisons made

    t8c_core dut (
        .I_REF_CLK         (clk),
        .I_RESET           (reset),
        .I_BUS_REQ         (req),
        .O_WAITREQUEST     (wait_req),
        .O_READDATA        (rdata),
        .I_EXT_COUNT_INPUT (ext),
        .I_INT_ACK         (ack),
        .O_INT_REQ         (int_req),
        .O_WAVE_OUT_A      (wave_a),
        .O_WAVE_OUT_B      (wave_b)
    );

    // 100 mhz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // verdict and end of run, shared with the watchdog
    task automatic stop_test();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // one comparison, counted
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // one avalon access, held until waitrequest is low at an edge; watchdog ends a hang
    task automatic bus(input logic wr_en, input logic [4:0] a, input logic [7:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        req <= '{read: ~wr_en, write: wr_en, address: a, byteenable: 4'hf,
                 writedata: {24'h000000, d}};
        do begin
            @(posedge clk);
        end while (wait_req !== 1'b0);
        q = rdata;
        req <= '0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp, input string what);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q, {24'h000000, exp}, what);
    endtask

    // reset values, read-back of the byte registers, unmapped hole
    task automatic t_regs();
        rd_chk(ADDR_COUNT, 8'h00, "count reset");
        rd_chk(ADDR_FLAGS, 8'h00, "flags reset");
        wr(ADDR_COUNT, 8'ha5);
        wr(ADDR_CMP_A, 8'h5a);
        wr(ADDR_CMP_B, 8'hc3);
        wr(5'h1c, 8'hff);
        repeat (20) @(posedge clk);
        rd_chk(ADDR_COUNT, 8'ha5, "stopped count held");
        rd_chk(ADDR_CMP_A, 8'h5a, "compare a");
        rd_chk(ADDR_CMP_B, 8'hc3, "compare b");
        rd_chk(5'h1c, 8'h00, "unmapped read");
    endtask

    // overflow at wrap in normal mode, service acknowledge clears it
    task automatic t_overflow();
        logic [31:0] q;
        int          n;
        wr(ADDR_MASK, 8'h01);
        wr(ADDR_COUNT, 8'hfe);
        wr(ADDR_CTRL_B, {5'h00, CS_DIV1});
        n = 0;
        while (int_req[FLAG_OVF] !== 1'b1 && n < 10) begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, int_req[FLAG_OVF]}, 32'h1, "overflow request");
        ack <= 3'b001;
        @(posedge clk);
        ack <= 3'b000;
        @(posedge clk);
        chk({31'h0, int_req[FLAG_OVF]}, 32'h0, "overflow serviced");
        wr(ADDR_CTRL_B, {5'h00, CS_STOP});
        bus(1'b0, ADDR_COUNT, 8'h00, q);
        chk({31'h0, q < 32'h20}, 32'h1, "count wrapped to bottom");
        wr(ADDR_MASK, 8'h00);
    endtask

    // both comparators, flags visible while masked, toggle on match
    task automatic t_match();
        wr(ADDR_FLAGS, 8'h07);
        wr(ADDR_CTRL_A, 8'h40);
        wr(ADDR_CMP_A, 8'h05);
        wr(ADDR_CMP_B, 8'h06);
        wr(ADDR_COUNT, 8'h00);
        chk({31'h0, wave_a}, 32'h0, "wave a before");
        wr(ADDR_CTRL_B, {5'h00, CS_DIV1});
        repeat (12) @(posedge clk);
        wr(ADDR_CTRL_B, {5'h00, CS_STOP});
        rd_chk(ADDR_FLAGS, 8'h06, "match flags");
        chk({29'h0, int_req}, 32'h0, "masked requests");
        chk({31'h0, wave_a}, 32'h1, "wave a toggled");
        chk({31'h0, wave_b}, 32'h0, "wave b untouched");
        wr(ADDR_MASK, 8'h07);
        @(posedge clk);
        chk({29'h0, int_req}, 32'h6, "unmasked requests");
        // service of match a drops only its request
        ack <= 3'b010;
        @(posedge clk);
        ack <= 3'b000;
        @(posedge clk);
        chk({29'h0, int_req}, 32'h4, "match a serviced");
        wr(ADDR_FLAGS, 8'h04);
        rd_chk(ADDR_FLAGS, 8'h00, "write one clears");
        chk({29'h0, int_req}, 32'h0, "requests dropped");
        wr(ADDR_MASK, 8'h00);
    endtask

    // force strobe with every output action, no flag, no counter change
    task automatic t_force();
        logic [1:0] acts [4];
        logic       exps [4];
        acts = '{2'h2, 2'h3, 2'h0, 2'h1};
        exps = '{1'b0, 1'b1, 1'b1, 1'b0};
        wr(ADDR_COUNT, 8'h33);
        wr(ADDR_FLAGS, 8'h07);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CTRL_A, {acts[i], 6'h00});
            wr(ADDR_CTRL_B, 8'h80);
            repeat (2) @(posedge clk);
            chk({31'h0, wave_a}, {31'h0, exps[i]}, "forced wave a");
        end
        rd_chk(ADDR_FLAGS, 8'h00, "force sets no flag");
        rd_chk(ADDR_COUNT, 8'h33, "force keeps count");
        wr(ADDR_CTRL_A, 8'h00);
    endtask

    // counter write equal to compare blocks the first match
    task automatic t_block();
        wr(ADDR_CMP_A, 8'h20);
        wr(ADDR_FLAGS, 8'h07);
        wr(ADDR_COUNT, 8'h20);
        wr(ADDR_CTRL_B, {5'h00, CS_DIV1});
        repeat (10) @(posedge clk);
        wr(ADDR_CTRL_B, {5'h00, CS_STOP});
        rd_chk(ADDR_FLAGS, 8'h00, "blocked match");
    endtask

    // counter must never pass top in a clear-on-match or top-from-a mode
    task automatic t_top(input logic [2:0] mode, input logic [7:0] top);
        logic [31:0] q;
        wr(ADDR_CTRL_A, 8'h00);
        wr(ADDR_CTRL_B, 8'h00);
        wr(ADDR_CMP_A, top);
        wr(ADDR_COUNT, 8'h00);
        wr(ADDR_CTRL_A, {6'h00, mode[1:0]});
        wr(ADDR_CTRL_B, {4'h0, mode[2], CS_DIV1});
        for (int i = 0; i < 12; i++) begin
            bus(1'b0, ADDR_COUNT, 8'h00, q);
            chk({31'h0, q <= {24'h0, top}}, 32'h1, "count within top");
        end
        wr(ADDR_CTRL_B, 8'h00);
        wr(ADDR_CTRL_A, 8'h00);
    endtask

    // pwm compare writes reach the buffer; matches use the working copy
    task automatic t_buffer();
        wr(ADDR_CMP_A, 8'h10);
        wr(ADDR_CTRL_A, {6'h00, MODE_FAST[1:0]});
        wr(ADDR_CMP_A, 8'h80);
        rd_chk(ADDR_CMP_A, 8'h80, "buffer read back");
        wr(ADDR_COUNT, 8'h00);
        wr(ADDR_FLAGS, 8'h07);
        wr(ADDR_CTRL_B, {5'h00, CS_DIV1});
        repeat (25) @(posedge clk);
        wr(ADDR_CTRL_B, 8'h00);
        rd_chk(ADDR_FLAGS, 8'h06, "match on working copy");
        wr(ADDR_CTRL_A, 8'h00);
    endtask

    // prescaled rates and the external pin on both edges
    task automatic t_clock_select();
        logic [2:0]  codes [4];
        int          divs [4];
        logic [31:0] q;
        codes = '{CS_DIV8, CS_D64, CS_D256, CS_D1K};
        divs = '{8, 64, 256, 1024};
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_COUNT, 8'h00);
            wr(ADDR_CTRL_B, {5'h00, codes[i]});
            repeat (10 * divs[i]) @(posedge clk);
            wr(ADDR_CTRL_B, 8'h00);
            bus(1'b0, ADDR_COUNT, 8'h00, q);
            chk({31'h0, q >= 32'h9 && q <= 32'hb}, 32'h1, "prescaled count");
        end
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_COUNT, 8'h00);
            wr(ADDR_CTRL_B, {5'h00, (i == 0) ? CS_FALL : CS_RISE});
            for (int k = 0; k < 5; k++) begin
                ext <= 1'b1;
                repeat (3) @(posedge clk);
                ext <= 1'b0;
                repeat (3) @(posedge clk);
            end
            repeat (3) @(posedge clk);
            wr(ADDR_CTRL_B, 8'h00);
            rd_chk(ADDR_COUNT, 8'h05, "pin edge count");
        end
        repeat (20) @(posedge clk);
        rd_chk(ADDR_COUNT, 8'h05, "stopped after select zero");
    endtask

    // watchdog, far beyond the expected run of about 14k cycles
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        stop_test();
    end

    // main sequence
    initial begin
        n_mismatch = 0;
        check_count = 0;
        reset = 1'b1;
        req = '0;
        ext = 1'b0;
        ack = 3'b000;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_overflow();
        t_match();
        t_force();
        t_block();
        t_top(MODE_CTC, 8'h03);
        t_top(MODE_FAST_OCR, 8'h08);
        t_buffer();
        t_clock_select();
        stop_test();
    end
endmodule
`default_nettype wire
